// *** test/iasf_far_end.sv ***
// far side of the two-wire bus: another master driving clock and data
`default_nettype none
module iasf_far_end (
  // bus lines as the device sees them
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // both lines pulled up, so idle is high
  initial begin
    scl = 1'h1;
    sda = 1'h1;
  end
  task automatic start();
    sda = 1'h0;
    #62.5;
  endtask
  // msb first, data changes only while the clock is low
  task automatic bits(input logic [8:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      scl = 1'h0;
      #31.25 sda = v[i];
      #31.25 scl = 1'h1;
      #62.5;
    end
  endtask
  task automatic stop();
    scl = 1'h0;
    #31.25 sda = 1'h0;
    #31.25 scl = 1'h1;
    #31.25 sda = 1'h1;
    #31.25;
  endtask
endmodule
`default_nettype wire

// *** test/iasf_status_chk.sv ***
// port-level concurrent checks for the bus status flag block
`default_nettype none
module iasf_status_chk #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic              mclk,
  input wire logic              resetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // bus pins and interrupt
  input wire logic              scl_in,
  input wire logic              sda_in,
  input wire logic              sda_drive_level,
  input wire logic              irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire rd_setup = psel && !penable && !pwrite;
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access");
  property p_err_acc; pslverr |-> psel && penable; endproperty
  a_err_acc: assert property (p_err_acc) else $error("error outside access");
  property p_unmapped; psel && penable && paddr >= 8'h18 |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped; psel && penable && paddr == 8'h00 |-> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("status access refused");
  property p_hold; !rd_setup |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_status_bits; rd_setup && paddr == 8'h00 |=> (prdata & ~32'h26) == 32'h0; endproperty
  a_status_bits: assert property (p_status_bits) else $error("status unused bits set");
  property p_bus_ro; rd_setup && paddr == 8'h14 |=> prdata[31:2] == 30'h0; endproperty
  a_bus_ro: assert property (p_bus_ro) else $error("pin register upper bits set");
  property p_rst; $rose(resetn) |-> prdata == 32'h0 && !irq; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_mask_off; psel && penable && pwrite && paddr == 8'h04 && pwdata == 32'h0 |-> ##2 !irq; endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq with all masked");
  c_err: cover property (psel && penable && pslverr);
  c_irq: cover property ($rose(irq));
  c_arb: cover property (rd_setup && paddr == 8'h00 ##1 prdata[2]);
endmodule
bind iasf_status iasf_status_chk #(.ADDR_W(ADDR_W)) u_iasf_status_chk (.mclk, .resetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_in, .sda_in, .sda_drive_level, .irq);
`default_nettype wire

// *** test/tb_iasf_status.sv ***
// self-checking bench for the bus status flag block
`default_nettype none
module tb_iasf_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, resetn, psel, penable, pwrite, sda_drive_level;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, irq, scl, sda, e;
  int          mismatches, checks_done;
  // address, write data, expected read; rows from 6 on are written first
  logic [71:0] rows [9] = '{72'h00_00000000_00000000, 72'h04_00000000_00000000, 72'h08_00000000_00000000,
    72'h0C_00000000_00000000, 72'h10_00000000_00000000, 72'h14_00000000_00000003,
    72'h04_FFFFFFFF_00000026, 72'h08_00000007_00000007, 72'h0C_000000AA_000000AA};
  iasf_status #(.ADDR_W(8)) u_iasf_status (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl), .sda_in(sda), .sda_drive_level(sda_drive_level), .irq(irq));
  iasf_far_end u_iasf_far_end (.scl(scl), .sda(sda));
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  // wait states are allowed: the access cycle is held until ready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1) @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input string n, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(n, r, x);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic irq_is(input logic x);
    repeat (2) @(posedge mclk);
    #1 chk("irq", {31'h0, irq}, {31'h0, x});
  endtask
  initial begin
    #200_000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata, mismatches, checks_done} = '0;
    sda_drive_level = 1'h1;
    repeat (16) @(posedge mclk);
    resetn <= 1'h1;
    for (int i = 0; i < 9; i++) begin
      if (i > 5) wr(rows[i][71:64], rows[i][63:32]);
      rd(rows[i][71:64], "row", rows[i][31:0]);
    end
    rd(8'h40, "unmapped", 32'h0);
    chk("slverr", {31'h0, e}, 32'h1);
    // slave: own address, then a data byte
    wr(8'h08, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h0C, 32'h2A);
    u_iasf_far_end.start();
    u_iasf_far_end.bits(9'h0A9, 9);
    rd(8'h00, "match", 32'h2);
    u_iasf_far_end.bits(9'h187, 9);
    rd(8'h00, "rx_full", 32'h22);
    rd(8'h10, "rx_buf", 32'hC3);
    rd(8'h00, "rx_read", 32'h2);
    u_iasf_far_end.stop();
    // ones never clear, and a write without a fresh read is ignored
    wr(8'h00, 32'h26);
    wr(8'h00, 32'h0);
    rd(8'h00, "no_arm", 32'h2);
    wr(8'h00, 32'h0);
    rd(8'h00, "cleared", 32'h0);
    u_iasf_far_end.start();
    u_iasf_far_end.bits(9'h0AD, 9);
    u_iasf_far_end.bits(9'h187, 9);
    rd(8'h00, "other_addr", 32'h0);
    u_iasf_far_end.stop();
    wr(8'h0C, 32'hAA);
    u_iasf_far_end.start();
    u_iasf_far_end.bits(9'h001, 9);
    rd(8'h00, "gcall", 32'h2);
    u_iasf_far_end.stop();
    // interrupt follows the masked status
    wr(8'h04, 32'h2);
    irq_is(1'h1);
    wr(8'h04, 32'h0);
    irq_is(1'h0);
    wr(8'h04, 32'h2);
    rd(8'h00, "arm", 32'h2);
    wr(8'h00, 32'h0);
    irq_is(1'h0);
    // master transmit: matching bit, then a lost bit
    wr(8'h08, 32'h3);
    @(posedge mclk) sda_drive_level <= 1'h0;
    u_iasf_far_end.start();
    u_iasf_far_end.bits(9'h0, 1);
    rd(8'h00, "arb_same", 32'h0);
    @(posedge mclk) sda_drive_level <= 1'h1;
    u_iasf_far_end.bits(9'h0, 1);
    rd(8'h00, "arb_lost", 32'h4);
    u_iasf_far_end.stop();
    wr(8'h00, 32'h0);
    rd(8'h00, "al_clear", 32'h0);
    // another master starts while this one holds the line released
    wr(8'h08, 32'h1);
    u_iasf_far_end.start();
    rd(8'h00, "contend", 32'h4);
    u_iasf_far_end.stop();
    wr(8'h00, 32'h0);
    // clocked synchronous: second frame while still full
    wr(8'h08, 32'h4);
    u_iasf_far_end.bits(9'h0A5, 8);
    rd(8'h00, "sync_full", 32'h20);
    u_iasf_far_end.bits(9'h03C, 8);
    rd(8'h00, "overrun", 32'h24);
    rd(8'h10, "kept_byte", 32'hA5);
    u_iasf_far_end.bits(9'h0F0, 8);
    rd(8'h00, "full_again", 32'h24);
    wr(8'h00, 32'h0);
    rd(8'h00, "rx_cleared", 32'h0);
    @(posedge mclk) resetn <= 1'h0;
    repeat (2) @(posedge mclk);
    resetn <= 1'h1;
    rd(8'h00, "mid_reset", 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** verilog/iasf_params.svh ***
// register map, field positions and reset values of the bus status flag block
//
// Operation
// - As master, seeing bus data that differs from what was sent sets the arbitration-lost flag.
// - In master transmit mode the driven data level is compared with the pin at each clock rise; a mismatch sets it.
// - In master mode a start condition seen while the data line is released high sets it.
// - In clocked synchronous mode a final bit received while the buffer is still full sets the same flag as overrun.
// - The arbitration-lost/overrun flag clears only when read as 1 and then written with 0.
// - In slave mode a first frame after start that matches the seven-bit own address sets the match flag.
// - In slave mode a general call address as first frame after start also sets the match flag.
// - The arbitration-lost/overrun flag is status bit 2, read/write, reset 0.
// - The own-address match flag is status bit 1, read/write, reset 0.
// - The receive-full flag sets when a frame moves into the buffer and clears on buffer read or read-1-write-0.
`ifndef IASF_PARAMS_SVH
`define IASF_PARAMS_SVH

// ================================================================
// register offsets
`define IASF_OFS_STATUS 8'h00
`define IASF_OFS_MASK   8'h04
`define IASF_OFS_CTRL   8'h08
`define IASF_OFS_SADDR  8'h0C
`define IASF_OFS_RXBUF  8'h10
`define IASF_OFS_BUS    8'h14

// ================================================================
// status fields
`define IASF_ST_MATCH   1
`define IASF_ST_ALOVE   2
`define IASF_ST_RXFULL  5
`define IASF_ST_USED    8'h26

// ================================================================
// control and address fields
`define IASF_CT_MASTER  0
`define IASF_CT_TX      1
`define IASF_CT_SYNC    2
`define IASF_SA_GCEN    7
`define IASF_GCALL_ADDR 7'h00

// ================================================================
// frame shape and reset values
`define IASF_LAST_BIT   4'h7
`define IASF_ACK_BIT    4'h8
`define IASF_RST_FLAG   1'h0
`define IASF_RST_BYTE   8'h00

`endif

// *** verilog/iasf_pkg.sv ***
// types shared by the bus status flag block
`default_nettype none
package iasf_pkg;
  typedef enum logic [1:0] {
    iasf_idle,
    iasf_addr_frame,
    iasf_data_frame
  } iasf_frame_t;
endpackage
`default_nettype wire

// *** verilog/iasf_status.sv ***
// two-wire bus status flags: arbitration lost / overrun, own address match, receive full
`include "iasf_params.svh"
`default_nettype none
module iasf_status #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              resetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // bus pins, asynchronous
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  // level the transmitter drives on the data line, 1 = released
  input  wire logic              sda_drive_level,
  // interrupt
  output logic                   irq
);

  // the register offsets need a full byte of address
  if (ADDR_W < 8) begin : g_addr_w_check
    $error("ADDR_W must be at least 8");
  end

  // ================================================================
  // register state
  logic                   arb_lost_overrun_flag;
  logic                   own_address_match_flag;
  logic                   rx_buffer_full_flag;
  logic [7:0]             irq_mask;
  logic                   ctl_master;
  logic                   ctl_tx;
  logic                   ctl_sync;
  logic [6:0]             own_address;
  logic                   gcall_enable;
  logic [7:0]             receive_buffer;
  logic [2:0]             clear_armed;

  // ================================================================
  // pin synchronisers
  logic                   scl_meta;
  logic                   scl_sync;
  logic                   scl_prev;
  logic                   sda_meta;
  logic                   sda_sync;
  logic                   sda_prev;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      scl_meta <= 1'h1;
      scl_sync <= 1'h1;
      scl_prev <= 1'h1;
      sda_meta <= 1'h1;
      sda_sync <= 1'h1;
      sda_prev <= 1'h1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  logic scl_rise;
  logic start_seen;
  logic stop_seen;
  assign scl_rise   = scl_sync && !scl_prev;
  // data moving while the clock is high marks start or stop
  assign start_seen = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign stop_seen  = scl_sync && scl_prev && !sda_prev && sda_sync;

  // ================================================================
  // apb decode
  logic       acc;
  logic       setup;
  logic       wr_acc;
  logic       rd_acc;
  logic       hit_status;
  logic       hit_mask;
  logic       hit_ctrl;
  logic       hit_saddr;
  logic       hit_rxbuf;
  logic       hit_bus;
  logic       mapped;
  logic [7:0] offs;

  assign offs   = paddr[7:0];
  assign acc    = psel && penable;
  assign setup  = psel && !penable;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;

  always_comb begin
    hit_status = 1'h0;
    hit_mask   = 1'h0;
    hit_ctrl   = 1'h0;
    hit_saddr  = 1'h0;
    hit_rxbuf  = 1'h0;
    hit_bus    = 1'h0;
    if ((paddr >> $bits(offs)) != '0) begin
      hit_status = 1'h0;
    end else if (offs == `IASF_OFS_STATUS) begin
      hit_status = 1'h1;
    end else if (offs == `IASF_OFS_MASK) begin
      hit_mask = 1'h1;
    end else if (offs == `IASF_OFS_CTRL) begin
      hit_ctrl = 1'h1;
    end else if (offs == `IASF_OFS_SADDR) begin
      hit_saddr = 1'h1;
    end else if (offs == `IASF_OFS_RXBUF) begin
      hit_rxbuf = 1'h1;
    end else if (offs == `IASF_OFS_BUS) begin
      hit_bus = 1'h1;
    end
  end

  assign mapped  = hit_status || hit_mask || hit_ctrl || hit_saddr || hit_rxbuf || hit_bus;
  // zero wait states: every access finishes in its first access cycle
  assign pready  = 1'h1;
  assign pslverr = acc && !mapped;

  logic [7:0] status_view;
  assign status_view = {2'h0, rx_buffer_full_flag, 2'h0, arb_lost_overrun_flag,
                        own_address_match_flag, 1'h0};

  // read data is captured in the setup cycle so it stands through the access
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prdata <= 32'h0;
    end else if (setup && !pwrite) begin
      if (hit_status) begin
        prdata <= {24'h0, status_view};
      end else if (hit_mask) begin
        prdata <= {24'h0, irq_mask};
      end else if (hit_ctrl) begin
        prdata <= {29'h0, ctl_sync, ctl_tx, ctl_master};
      end else if (hit_saddr) begin
        prdata <= {24'h0, gcall_enable, own_address};
      end else if (hit_rxbuf) begin
        prdata <= {24'h0, receive_buffer};
      end else if (hit_bus) begin
        prdata <= {30'h0, sda_sync, scl_sync};
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  // ================================================================
  // control registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irq_mask     <= `IASF_RST_BYTE;
      ctl_master   <= `IASF_RST_FLAG;
      ctl_tx       <= `IASF_RST_FLAG;
      ctl_sync     <= `IASF_RST_FLAG;
      own_address  <= 7'h00;
      gcall_enable <= `IASF_RST_FLAG;
    end else if (wr_acc) begin
      if (hit_mask) begin
        irq_mask <= pwdata[7:0] & `IASF_ST_USED;
      end
      if (hit_ctrl) begin
        ctl_master <= pwdata[`IASF_CT_MASTER];
        ctl_tx     <= pwdata[`IASF_CT_TX];
        ctl_sync   <= pwdata[`IASF_CT_SYNC];
      end
      if (hit_saddr) begin
        own_address  <= pwdata[6:0];
        gcall_enable <= pwdata[`IASF_SA_GCEN];
      end
    end
  end

  // ================================================================
  // frame tracking and receive shifting
  iasf_pkg::iasf_frame_t frame;
  logic [3:0]            bit_cnt;
  logic [7:0]            shift_register;
  logic [7:0]            next_shift;
  logic                  frame_done;
  logic                  addressed;
  logic                  addr_hit;
  logic                  overrun_hit;
  logic                  rx_load;
  logic                  arb_hit;

  assign next_shift = {shift_register[6:0], sda_sync};
  assign frame_done = scl_rise && (bit_cnt == `IASF_LAST_BIT)
                      && (ctl_sync || frame != iasf_pkg::iasf_idle);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      frame          <= iasf_pkg::iasf_idle;
      bit_cnt        <= 4'h0;
      shift_register <= `IASF_RST_BYTE;
    end else if (ctl_sync) begin
      frame <= iasf_pkg::iasf_idle;
      if (scl_rise) begin
        shift_register <= next_shift;
        bit_cnt        <= frame_done ? 4'h0 : bit_cnt + 4'h1;
      end
    end else if (start_seen) begin
      frame   <= iasf_pkg::iasf_addr_frame;
      bit_cnt <= 4'h0;
    end else if (stop_seen) begin
      frame   <= iasf_pkg::iasf_idle;
      bit_cnt <= 4'h0;
    end else if (scl_rise && frame != iasf_pkg::iasf_idle) begin
      if (bit_cnt == `IASF_ACK_BIT) begin
        // acknowledge clock closes the frame; later frames carry data
        bit_cnt <= 4'h0;
        frame   <= iasf_pkg::iasf_data_frame;
      end else begin
        shift_register <= next_shift;
        bit_cnt        <= bit_cnt + 4'h1;
      end
    end
  end

  // first frame after start compared with own and general call address
  assign addr_hit = !ctl_sync && !ctl_master && frame_done
                    && frame == iasf_pkg::iasf_addr_frame
                    && (next_shift[7:1] == own_address
                        || (gcall_enable && next_shift[7:1] == `IASF_GCALL_ADDR));

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      addressed <= 1'h0;
    end else if (start_seen || stop_seen || ctl_sync) begin
      addressed <= 1'h0;
    end else if (addr_hit) begin
      addressed <= 1'h1;
    end
  end

  // a full buffer is never overwritten: the new frame is dropped
  assign overrun_hit = ctl_sync && frame_done && rx_buffer_full_flag;
  assign rx_load     = frame_done && !rx_buffer_full_flag
                       && (ctl_sync || (frame == iasf_pkg::iasf_data_frame && (addressed || ctl_master)));

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      receive_buffer <= `IASF_RST_BYTE;
    end else if (rx_load) begin
      receive_buffer <= next_shift;
    end
  end

  // arbitration: driven level against pin at clock rise, or start while released
  assign arb_hit = !ctl_sync && ctl_master
                   && ((ctl_tx && scl_rise && sda_drive_level != sda_sync)
                       || (start_seen && sda_drive_level));

  // ================================================================
  // status flags
  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic armed, input logic clr_wr,
                                     input logic wbit);
    logic nxt;
    nxt = cur;
    // only a 0 after a 1 was read clears; a 1 written changes nothing
    if (clr_wr && armed && !wbit) begin
      nxt = 1'h0;
    end
    if (set) begin
      nxt = 1'h1;
    end
    return nxt;
  endfunction

  logic st_wr;
  logic rx_read;
  assign st_wr   = wr_acc && hit_status;
  assign rx_read = rd_acc && hit_rxbuf;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      clear_armed <= 3'h0;
    end else if (rd_acc && hit_status) begin
      // arm from what software was shown, not from a flag that rose after setup
      clear_armed <= {prdata[`IASF_ST_RXFULL], prdata[`IASF_ST_ALOVE], prdata[`IASF_ST_MATCH]};
    end else if (st_wr) begin
      clear_armed <= 3'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      arb_lost_overrun_flag <= `IASF_RST_FLAG;
    end else begin
      arb_lost_overrun_flag <= flag_next(arb_lost_overrun_flag, arb_hit || overrun_hit,
                                         clear_armed[1], st_wr, pwdata[`IASF_ST_ALOVE]);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      own_address_match_flag <= `IASF_RST_FLAG;
    end else begin
      own_address_match_flag <= flag_next(own_address_match_flag, addr_hit,
                                          clear_armed[0], st_wr, pwdata[`IASF_ST_MATCH]);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rx_buffer_full_flag <= `IASF_RST_FLAG;
    end else if (rx_load) begin
      rx_buffer_full_flag <= 1'h1;
    end else if (rx_read) begin
      rx_buffer_full_flag <= 1'h0;
    end else begin
      rx_buffer_full_flag <= flag_next(rx_buffer_full_flag, 1'h0,
                                       clear_armed[2], st_wr, pwdata[`IASF_ST_RXFULL]);
    end
  end

  // ================================================================
  // interrupt
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irq <= 1'h0;
    end else begin
      irq <= |(status_view & irq_mask);
    end
  end

endmodule
`default_nettype wire
